// *** core/pattern_test_pkg.sv ***
// shared constants and types of the pattern test unit
// assumes a 128-bit pattern fifo counted in 16-byte words
package pattern_test_pkg;
	localparam int WORD_W = 128;
	localparam int ADDR_W = 48;
	localparam int LEN_W = 32;
	localparam int FILL_W = 16;
	localparam int CNT_W = 9;
	localparam int SEL_W = 3;
	localparam int AXI_ADDR_W = 8;
	localparam int IRQ_W = 2;

	// one 8-Kbyte burst is 512 words, or 16 units of 512 bytes
	localparam int BURST_SHIFT = 4;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 48'h10;
	localparam logic [LEN_W-1:0] UNIT_ONE = 32'h1;
	localparam logic [LEN_W-1:0] UNIT_NONE = 32'h0;
	localparam logic [FILL_W-1:0] FILL_BURST_MIN = 16'h0200;
	localparam logic [FILL_W-1:0] FILL_CONTINUE_MIN = 16'h0220;
	localparam logic [CNT_W-1:0] WORD_IDX_511TH = 9'h1fe;
	localparam logic [CNT_W-1:0] WORD_CNT_ONE = 9'h001;

	// register byte offsets
	localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] REG_LEN = 8'h04;
	localparam logic [AXI_ADDR_W-1:0] REG_ADDR_LO = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] REG_ADDR_HI = 8'h0c;
	localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h10;
	localparam logic [AXI_ADDR_W-1:0] REG_IRQ_STATUS = 8'h14;
	localparam logic [AXI_ADDR_W-1:0] REG_IRQ_MASK = 8'h18;

	// field positions
	localparam int CTRL_WRITE_BIT = 0;
	localparam int CTRL_READ_BIT = 1;
	localparam int CTRL_SEL_LSB = 8;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_FAIL_BIT = 1;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		st_wait_start,
		st_read_issue,
		st_write_wait_fill,
		st_write_burst,
		st_write_check_fill,
		st_wait_done
	} cmd_state_t;
endpackage

// *** core/verify_if.sv ***
// signals between the command sequencer and the read-data checker
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface verify_if;
	logic read_active;
	logic test_start;
	logic read_word_valid;
	logic [127:0] read_word;
	logic [127:0] head_word;
	logic pop;
	logic fail;
	modport sequencer (output read_active, test_start, read_word_valid,
		read_word, head_word, input pop, fail);
	modport verifier (input read_active, test_start, read_word_valid,
		read_word, head_word, output pop, fail);
endinterface
`default_nettype wire

// *** core/read_verifier.sv ***
// read-data checker: pops expected words and flags any mismatch
// assumes the core returns read words in command order, no gaps
`timescale 1ns/1ps
`default_nettype none
module read_verifier
	import pattern_test_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// link to the sequencer
	verify_if.verifier vif
);
	logic fail_q;
	logic mismatch;

	// read-valid is the pop itself; expected word is the fifo head
	assign vif.pop = vif.read_active & vif.read_word_valid;
	assign mismatch = vif.pop && (vif.read_word != vif.head_word);
	assign vif.fail = fail_q;

	// a mismatch in the start cycle still counts
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			fail_q <= 1'b0;
		else if (mismatch)
			fail_q <= 1'b1;
		else if (vif.test_start)
			fail_q <= 1'b0;
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	AST_FAIL_ON_MISMATCH: assert property (mismatch |=> fail_q[*2])
		else $error("mismatch did not raise the fail flag");
	AST_FAIL_CLEAR_ON_START: assert property
		(vif.test_start && !mismatch |=> !fail_q)
		else $error("fail flag not cleared by a new test");
	AST_FAIL_STICKY: assert property
		(fail_q && !vif.test_start |=> fail_q)
		else $error("fail flag dropped without a new test");
	AST_NO_FAIL_OUTSIDE_READ: assert property
		(!vif.read_active && !fail_q |=> !fail_q)
		else $error("fail flag rose outside a read test");
endmodule
`default_nettype wire

// *** core/pattern_test_unit.sv ***
// command sequencer of the storage pattern test, with axi4-lite registers
// assumes the core's command port and the fwft fifo share i_core_clk
//
// Function
// - idle request loads length, address, pattern and raises running flag
// - read request goes to read issue, write request to fill wait
// - one read command per 8-Kbyte unit, then wait for done
// - write waits until the fifo holds at least one burst
// - fifo head drives write data; pop on write command without stall, or on read valid in read tests
// - first burst cycle shows first word, address and write command
// - after 511th accepted word go to check, sending the last word
// - after last word: finish, wait for fill, or continue burst
// - continue only when fill count exceeds 544 words
// - stall during write holds the current write word
// - read command taken when stall low; address held meanwhile
// - read command stays high until the final one is taken
// - when registered core busy is low, clear running and go idle
// - checking only in read tests; read valid pops expected data
// - each read word compared; mismatch raises the fail flag
// - pattern fifo is first-word-fall-through
`timescale 1ns/1ps
`default_nettype none
module pattern_test_unit
	import pattern_test_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// axi4-lite slave
	input wire logic [AXI_ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [AXI_ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// storage core command port
	output logic o_mm_write_cmd,
	output logic o_mm_read_cmd,
	output logic [ADDR_W-1:0] o_mm_cmd_addr,
	output logic [WORD_W-1:0] o_mm_write_word,
	input wire logic i_mm_stall,
	input wire logic [WORD_W-1:0] i_mm_read_word,
	input wire logic i_mm_read_word_valid,
	input wire logic i_core_busy_flag,
	// pattern fifo, fwft
	input wire logic [WORD_W-1:0] i_fifo_head_word,
	input wire logic [FILL_W-1:0] i_fifo_fill_count,
	output logic o_fifo_pop,
	// pattern generator and user status
	output logic o_test_start,
	output logic [SEL_W-1:0] o_pattern_select,
	output logic o_test_running_flag,
	output logic o_verify_fail_flag,
	output logic o_irq
);
	cmd_state_t cmd_state;
	logic [LEN_W-1:0] remaining_burst_count;
	logic [CNT_W-1:0] word_cnt;
	logic read_test;
	logic busy_q;
	logic wr_accept;
	logic rd_accept;
	logic write_req;
	logic read_req;
	logic [LEN_W-1:0] len_cfg;
	logic [ADDR_W-1:0] addr_cfg;
	logic [SEL_W-1:0] sel_cfg;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_events;
	logic fail_prev;
	logic aw_full;
	logic w_full;
	logic [AXI_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic wr_mapped;
	logic ar_take;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic [LEN_W-1:0] burst_units;
	logic [31:0] addr_hi_merged;

	verify_if vif();

	read_verifier u_read_verifier (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.vif(vif.verifier)
	);

	assign vif.read_active = read_test && o_test_running_flag;
	assign vif.test_start = o_test_start;
	assign vif.read_word_valid = i_mm_read_word_valid;
	assign vif.read_word = i_mm_read_word;
	assign vif.head_word = i_fifo_head_word;
	assign o_verify_fail_flag = vif.fail;

	// fwft head goes straight out; pop must be same-cycle, so not a flop
	assign o_mm_write_word = i_fifo_head_word;
	assign wr_accept = o_mm_write_cmd && !i_mm_stall;
	assign rd_accept = o_mm_read_cmd && !i_mm_stall;
	assign o_fifo_pop = wr_accept || vif.pop;
	assign burst_units = len_cfg >> BURST_SHIFT;

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			busy_q <= 1'b0;
		else
			busy_q <= i_core_busy_flag;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cmd_state <= st_wait_start;
			o_mm_write_cmd <= 1'b0;
			o_mm_read_cmd <= 1'b0;
			o_mm_cmd_addr <= '0;
			remaining_burst_count <= '0;
			word_cnt <= '0;
			read_test <= 1'b0;
			o_test_running_flag <= 1'b0;
			o_test_start <= 1'b0;
			o_pattern_select <= '0;
		end
		else
		begin
			o_test_start <= 1'b0;
			case (cmd_state)
				st_wait_start:
					if (read_req || write_req)
					begin
						remaining_burst_count <= burst_units;
						o_mm_cmd_addr <= addr_cfg;
						o_pattern_select <= sel_cfg;
						o_test_running_flag <= 1'b1;
						o_test_start <= 1'b1;
						read_test <= read_req;
						word_cnt <= '0;
						// nothing to move: skip straight to done
						if (burst_units == UNIT_NONE)
							cmd_state <= st_wait_done;
						else if (read_req)
						begin
							o_mm_read_cmd <= 1'b1;
							cmd_state <= st_read_issue;
						end
						else
							cmd_state <= st_write_wait_fill;
					end
				st_read_issue:
					if (rd_accept)
					begin
						if (remaining_burst_count == UNIT_ONE)
						begin
							o_mm_read_cmd <= 1'b0;
							cmd_state <= st_wait_done;
						end
						else
						begin
							// no wait for returned data
							o_mm_cmd_addr <= o_mm_cmd_addr + ADDR_STEP;
							remaining_burst_count <=
								remaining_burst_count - UNIT_ONE;
						end
					end
				st_write_wait_fill:
					if (i_fifo_fill_count >= FILL_BURST_MIN)
					begin
						o_mm_write_cmd <= 1'b1;
						word_cnt <= '0;
						cmd_state <= st_write_burst;
					end
				st_write_burst:
					if (wr_accept)
					begin
						word_cnt <= word_cnt + WORD_CNT_ONE;
						if (word_cnt == WORD_IDX_511TH)
							cmd_state <= st_write_check_fill;
					end
				st_write_check_fill:
					if (wr_accept)
					begin
						word_cnt <= '0;
						o_mm_cmd_addr <= o_mm_cmd_addr + ADDR_STEP;
						remaining_burst_count <=
							remaining_burst_count - UNIT_ONE;
						if (remaining_burst_count == UNIT_ONE)
						begin
							o_mm_write_cmd <= 1'b0;
							cmd_state <= st_wait_done;
						end
						// count lags pops, so demand more than one burst
						else if (i_fifo_fill_count > FILL_CONTINUE_MIN)
							cmd_state <= st_write_burst;
						else
						begin
							o_mm_write_cmd <= 1'b0;
							cmd_state <= st_write_wait_fill;
						end
					end
				st_wait_done:
					if (!busy_q)
					begin
						o_test_running_flag <= 1'b0;
						read_test <= 1'b0;
						cmd_state <= st_wait_start;
					end
				default:
					cmd_state <= st_wait_start;
			endcase
		end
	end

	// axi write: address and data taken in either order
	assign do_write = aw_full && w_full && !o_bvalid;
	assign wr_mapped = (aw_addr == REG_CTRL) || (aw_addr == REG_LEN) ||
		(aw_addr == REG_ADDR_LO) || (aw_addr == REG_ADDR_HI) ||
		(aw_addr == REG_IRQ_MASK);

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
		end
		else
		begin
			if (i_awvalid && o_awready)
			begin
				aw_addr <= i_awaddr;
				aw_full <= 1'b1;
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready)
			begin
				w_data <= i_wdata;
				w_strb <= i_wstrb;
				w_full <= 1'b1;
				o_wready <= 1'b0;
			end
			if (do_write)
			begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (o_bvalid && i_bready)
			begin
				o_bvalid <= 1'b0;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end
		end
	end

	function automatic logic [31:0] merge_bytes(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				res[b*8 +: 8] = val[b*8 +: 8];
		return res;
	endfunction

	// high word merged in full, then cut to the 16 address bits
	assign addr_hi_merged = merge_bytes({16'h0000, addr_cfg[ADDR_W-1:32]},
		w_data, w_strb);

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			len_cfg <= '0;
			addr_cfg <= '0;
			sel_cfg <= '0;
			irq_mask <= '0;
			write_req <= 1'b0;
			read_req <= 1'b0;
		end
		else
		begin
			write_req <= 1'b0;
			read_req <= 1'b0;
			if (do_write)
				case (aw_addr)
					REG_CTRL:
					begin
						// requests outside idle are dropped by the sequencer
						write_req <= w_strb[0] && w_data[CTRL_WRITE_BIT];
						read_req <= w_strb[0] && w_data[CTRL_READ_BIT];
						if (w_strb[1])
							sel_cfg <= w_data[CTRL_SEL_LSB +: SEL_W];
					end
					REG_LEN:
						len_cfg <= merge_bytes(len_cfg, w_data, w_strb);
					REG_ADDR_LO:
						addr_cfg[31:0] <= merge_bytes(addr_cfg[31:0],
							w_data, w_strb);
					REG_ADDR_HI:
						addr_cfg[ADDR_W-1:32] <=
							addr_hi_merged[ADDR_W-33:0];
					REG_IRQ_MASK:
						irq_mask <= w_data[IRQ_W-1:0];
					default:
						irq_mask <= irq_mask;
				endcase
		end
	end

	// axi read: one outstanding, answer one cycle after address
	assign ar_take = i_arvalid && o_arready;

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		next_rresp = RESP_OKAY;
		case (i_araddr)
			REG_CTRL:
				next_rdata[CTRL_SEL_LSB +: SEL_W] = sel_cfg;
			REG_LEN:
				next_rdata = len_cfg;
			REG_ADDR_LO:
				next_rdata = addr_cfg[31:0];
			REG_ADDR_HI:
				next_rdata[ADDR_W-33:0] = addr_cfg[ADDR_W-1:32];
			REG_STATUS:
				next_rdata[3:0] = {o_mm_read_cmd, o_mm_write_cmd,
					o_verify_fail_flag, o_test_running_flag};
			REG_IRQ_STATUS:
				next_rdata[IRQ_W-1:0] = irq_status;
			REG_IRQ_MASK:
				next_rdata[IRQ_W-1:0] = irq_mask;
			default:
				next_rresp = RESP_SLVERR;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= RESP_OKAY;
		end
		else if (ar_take)
		begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rdata <= next_rdata;
			o_rresp <= next_rresp;
		end
		else if (o_rvalid && i_rready)
		begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// sticky events; a read clears, but a same-cycle event survives
	assign irq_events[IRQ_DONE_BIT] = (cmd_state == st_wait_done) && !busy_q;
	assign irq_events[IRQ_FAIL_BIT] = o_verify_fail_flag && !fail_prev;

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			irq_status <= '0;
			fail_prev <= 1'b0;
			o_irq <= 1'b0;
		end
		else
		begin
			fail_prev <= o_verify_fail_flag;
			if (ar_take && (i_araddr == REG_IRQ_STATUS))
				irq_status <= irq_events;
			else
				irq_status <= irq_status | irq_events;
			o_irq <= |(irq_status & irq_mask);
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_idle_read_req;
		cmd_state == st_wait_start && read_req &&
		burst_units != UNIT_NONE;
	endsequence
	sequence s_read_issue_entered;
		cmd_state == st_read_issue && o_mm_read_cmd && o_test_running_flag;
	endsequence
	sequence s_final_word_taken;
		cmd_state == st_write_check_fill && wr_accept;
	endsequence

	AST_READ_START: assert property
		(s_idle_read_req |=> s_read_issue_entered)
		else $error("read request did not start a read test");
	AST_WRITE_START: assert property
		(cmd_state == st_wait_start && write_req && !read_req &&
		burst_units != UNIT_NONE |=> cmd_state == st_write_wait_fill &&
		!o_mm_write_cmd && o_mm_cmd_addr == $past(addr_cfg))
		else $error("write request did not enter fill wait");
	AST_FILL_HOLD: assert property
		(cmd_state == st_write_wait_fill &&
		i_fifo_fill_count < FILL_BURST_MIN |=> cmd_state == st_write_wait_fill)
		else $error("left fill wait with too little data");
	AST_BURST_FIRST: assert property
		(cmd_state == st_write_wait_fill &&
		i_fifo_fill_count >= FILL_BURST_MIN |=> cmd_state == st_write_burst
		&& o_mm_write_cmd && word_cnt == '0)
		else $error("burst did not open with the write command");
	AST_STALL_NO_POP: assert property
		(o_mm_write_cmd && i_mm_stall && !vif.read_active |-> !o_fifo_pop)
		else $error("fifo popped while the core stalled");
	AST_TO_CHECK: assert property
		(cmd_state == st_write_burst && wr_accept &&
		word_cnt == WORD_IDX_511TH |=> cmd_state == st_write_check_fill)
		else $error("511th word did not lead to the check state");
	AST_CONTINUE: assert property
		(s_final_word_taken and (remaining_burst_count != UNIT_ONE &&
		i_fifo_fill_count > FILL_CONTINUE_MIN) |=> cmd_state == st_write_burst
		&& o_mm_write_cmd)
		else $error("burst did not continue with enough data");
	AST_LAST_BURST: assert property
		(s_final_word_taken and (remaining_burst_count == UNIT_ONE)
		|=> cmd_state == st_wait_done && !o_mm_write_cmd)
		else $error("last burst did not end the write command");
	AST_READ_HOLD: assert property
		(o_mm_read_cmd && i_mm_stall |=> o_mm_read_cmd &&
		$stable(o_mm_cmd_addr))
		else $error("read address changed during stall");
	AST_READ_CMD_HELD: assert property
		(o_mm_read_cmd && !(rd_accept &&
		remaining_burst_count == UNIT_ONE) |=> o_mm_read_cmd)
		else $error("read command dropped before the final one");
	AST_DONE: assert property
		(cmd_state == st_wait_done && !busy_q |=> cmd_state == st_wait_start
		&& !o_test_running_flag)
		else $error("test did not finish after core went idle");
endmodule
`default_nettype wire

// *** testbench/storage_core_model.sv ***
// stand-in for the storage core: stalls, busy flag, in-order read return
// assumes the sequencer and this model share one clock
`timescale 1ns/1ps
`default_nettype none
module storage_core_model (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// command port
	input wire logic i_write_cmd,
	input wire logic i_read_cmd,
	input wire logic i_test_start,
	input wire logic i_slow,
	input wire logic [31:0] i_bad_idx,
	output logic o_stall,
	output logic [127:0] o_read_word,
	output logic o_read_valid,
	output logic o_busy
);
	logic [31:0] idx;
	logic [8:0] beat;
	logic [3:0] idle;
	logic run;
	logic busy;
	logic take;
	logic quiet;
	int pend;
	assign take = (i_write_cmd | i_read_cmd) & !o_stall;
	assign quiet = !(i_write_cmd || i_read_cmd || run || pend > 0);
	// busy shows in the very cycle of the first accept
	assign o_busy = busy | take;
	assign o_read_valid = run;
	// idle bus never repeats the last word
	assign o_read_word = run ? {4{idx ^ {31'h0, idx == i_bad_idx}}}
		: ~{4{idx}};
	always @(posedge i_core_clk or negedge i_rst_n)
		if (!i_rst_n)
		begin
			o_stall <= 1'b0;
			run <= 1'b0;
			beat <= 9'h0;
			idx <= 32'h0;
			idle <= 4'h0;
			busy <= 1'b0;
			pend <= 0;
		end
		else
		begin
			o_stall <= i_slow && ($urandom % 3 == 0);
			idx <= i_test_start ? 32'h0 : idx + {31'h0, run};
			beat <= run ? beat + 9'h1 : 9'h0;
			// one unit is 512 gapless words, units in command order
			if (!run && pend > 0)
				run <= 1'b1;
			else if (beat == 9'h1ff)
				run <= 1'b0;
			pend <= pend + int'(i_read_cmd & !o_stall)
				- int'(!run && pend > 0);
			idle <= quiet ? idle + {3'h0, idle != 4'hf} : 4'h0;
			// busy falls only after a long quiet spell
			if (take)
				busy <= 1'b1;
			else if (idle == 4'hf)
				busy <= 1'b0;
		end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench of the pattern test unit
// assumes the storage core model and a behavioural fwft fifo
`timescale 1ns/1ps
`default_nettype none
module testbench
	import pattern_test_pkg::*;
;
	logic clk = 0, rst_n = 0, slow = 0, pwc = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, bad = '1, pcnt = 0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, wc, rc, stall, rv;
	logic busy, pop, start, run, fail, irq;
	logic [1:0] bresp, rresp;
	logic [47:0] addr;
	logic [127:0] ww, rw;
	logic [15:0] fill = 0;
	logic [2:0] sel;
	logic [127:0] wq[$], aq[$];
	int miscompares = 0, n_compared = 0, cyc = 0, falls = 0, wk = 0;
	always #25 clk = ~clk;
	pattern_test_unit pattern_test_unit_i (
		.i_core_clk(clk), .i_rst_n(rst_n),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
		.i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
		.o_rvalid(rvalid), .i_rready(rready),
		.o_mm_write_cmd(wc), .o_mm_read_cmd(rc), .o_mm_cmd_addr(addr),
		.o_mm_write_word(ww), .i_mm_stall(stall), .i_mm_read_word(rw),
		.i_mm_read_word_valid(rv), .i_core_busy_flag(busy),
		.i_fifo_head_word({4{pcnt}}), .i_fifo_fill_count(fill),
		.o_fifo_pop(pop), .o_test_start(start), .o_pattern_select(sel),
		.o_test_running_flag(run), .o_verify_fail_flag(fail), .o_irq(irq)
	);
	storage_core_model storage_core_model_i (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_write_cmd(wc),
		.i_read_cmd(rc), .i_test_start(start), .i_slow(slow),
		.i_bad_idx(bad), .o_stall(stall), .o_read_word(rw),
		.o_read_valid(rv), .o_busy(busy)
	);
	// fwft fifo: head word is the running pop count
	always @(posedge clk)
	begin
		pcnt <= start ? 32'h0 : pcnt + {31'h0, pop};
		if (pop)
			fill <= fill - 16'h1;
	end
	task automatic chk_w(input logic [127:0] got, input logic [127:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			print_verdict;
		end
	end
	// results watcher, settled values at the falling edge
	always @(negedge clk)
	begin
		if (pwc && !wc)
			falls++;
		pwc = wc;
		if (wc && !stall)
		begin
			if (wk % 512 == 0)
				chk_w(addr, aq.pop_front());
			chk_w(ww, wq.pop_front());
			wk++;
		end
		if (rc && !stall)
			chk_w(addr, aq.pop_front());
	end
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// each channel released at its own take; response ends the wait
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		chk_w(bresp, er);
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		chk_w(rdata, d);
		chk_w(rresp, er);
		rready <= 1'b0;
	endtask
	task automatic start_test(input logic rd, input int units,
		input logic [47:0] a, input logic [15:0] f, input logic s,
		input logic [31:0] b, input logic [2:0] ps);
		@(posedge clk);
		slow <= s;
		bad <= b;
		fill <= f;
		wk = 0;
		falls = 0;
		for (int u = 0; u < units; u++)
			aq.push_back(a + 48'(u * 16));
		for (int k = 0; k < 512 * units && !rd; k++)
			wq.push_back({4{k[31:0]}});
		axi_wr(REG_LEN, 32'(units * 16), RESP_OKAY);
		axi_wr(REG_ADDR_LO, a[31:0], RESP_OKAY);
		axi_wr(REG_ADDR_HI, {16'h0, a[47:32]}, RESP_OKAY);
		axi_wr(REG_CTRL, {21'h0, ps, 6'h0, rd, !rd}, RESP_OKAY);
		while (!run)
			@(negedge clk);
		chk_w(sel, ps);
	endtask
	task automatic end_test(input logic [31:0] st, input int nf);
		while (run)
			@(negedge clk);
		chk_w(aq.size() + wq.size(), 0);
		axi_rd(REG_STATUS, st, RESP_OKAY);
		chk_w(fail, st[1]);
		if (nf > 0)
			chk_w(falls, nf);
		$display("test ended at %0t", $time);
	endtask
	initial
	begin
		void'($urandom(32'h1aa343be));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		axi_rd(REG_STATUS, 32'h0, RESP_OKAY);
		axi_rd(REG_IRQ_MASK, 32'h0, RESP_OKAY);
		axi_rd(8'h1c, 32'h0, RESP_SLVERR);
		axi_wr(8'h1c, 32'h5, RESP_SLVERR);
		axi_wr(REG_IRQ_MASK, 32'h3, RESP_OKAY);
		axi_rd(REG_IRQ_MASK, 32'h3, RESP_OKAY);
		$display("test registers ended");
		// starved fifo first, then 544 left after the burst
		start_test(0, 2, 48'h40, 16'd300, 0, '1, 3'h1);
		repeat (30) @(negedge clk);
		chk_w(wc, 1'b0);
		@(posedge clk);
		fill <= fill + 16'd755;
		end_test(32'h0, 2);
		chk_w(irq, 1'b1);
		axi_rd(REG_IRQ_STATUS, 32'h1, RESP_OKAY);
		repeat (3) @(negedge clk);
		chk_w(irq, 1'b0);
		// 545 left: next burst follows without a gap
		start_test(0, 2, 48'hfff0, 16'd1056, 1, '1, 3'h2);
		end_test(32'h0, 1);
		start_test(1, 3, 48'h1234_5678_9ab0, 16'hffff, 1, '1, 3'h4);
		// a second request while running must be dropped
		axi_wr(REG_CTRL, 32'h2, RESP_OKAY);
		end_test(32'h0, 0);
		start_test(1, 1, 48'h0, 16'hffff, 0, 32'd100, 3'h0);
		end_test(32'h2, 0);
		axi_rd(REG_IRQ_STATUS, 32'h3, RESP_OKAY);
		start_test(1, 1, 48'h20, 16'hffff, 0, '1, 3'h0);
		end_test(32'h0, 0);
		// zero length: no commands, straight to done
		start_test(1, 0, 48'h0, 16'hffff, 0, '1, 3'h5);
		end_test(32'h0, 0);
		print_verdict;
	end
endmodule
`default_nettype wire
